// ---- src/eiwm_core.sv ----
// Purpose: Exception selection and low-power wake-up for the core
// Assumes: Peripheral lines on clk, held until serviced; core acks
// Notes:   Lower priority value is the more urgent level
//
// What this block does
// - Unhandled memory, bus or usage faults escalate to hard fault, number 3.
// - Non-maskable exception 2 has no source and is never raised.
// - Exception 4 flags memory-protection faults, programmable priority.
// - Exception 5 flags bus faults, programmable priority.
// - Exception 6 flags usage faults, programmable priority.
// - Supervisor call is exception 11; numbers 7 to 10 and 13 unused.
// - Debug-monitor events raise exception 12, programmable priority.
// - Exception 14 is pendable service request, held; 15 is system tick.
// - In mode 1 any enabled peripheral request wakes the device.
// - In modes 2 and 3 only wake-capable sources wake; others stay pending.
// - Waking from mode 2 or 3 returns to active mode 0.
// - Inside a handler only a more urgent source may wake.
// - Positions 0 to 10 wake from modes 1, 2 and 3.
// - Positions 13, 15 to 39 and 44 to 54 wake from mode 1 only.
// - Position 25 is DMA error; 26 to 39 are DMA channel done.
// - Positions 44 to 54 carry second serial, logic, timer, pulse sources.
// - Each position records mode 1 and mode 2/3 wake capability.
// - Three priority bits, eight levels, level 0 after reset.
// - Equal levels resolve toward the lower position number.
// - Level 0 ranks below reset, non-maskable and hard fault.
`timescale 1ns/1ps

module eiwm_core
    import eiwm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          ce,
    // Peripheral requests
    input  wire eiwm_src_s                     src,
    input  wire logic [NUM_SRC-1:0]            src_enable,
    input  wire logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio,
    // Core fault and system events
    input  wire logic                          mem_fault,
    input  wire logic                          bus_fault,
    input  wire logic                          usage_fault,
    input  wire logic [2:0]                    fault_handler_en,
    input  wire logic                          svc_exec,
    input  wire logic                          debug_event,
    input  wire logic                          pend_svc_set,
    input  wire logic                          tick_event,
    input  wire logic [NUM_SYS-1:0][PRIO_W-1:0] sys_prio,
    // Core handler state
    input  wire logic                          handler_active,
    input  wire logic [PRIO_W-1:0]             active_prio,
    input  wire logic                          core_ack,
    input  wire logic [EXC_W-1:0]              core_ack_num,
    // Power control
    input  wire logic                          sleep_req,
    input  wire logic [1:0]                    sleep_mode,
    // Outputs
    output eiwm_exc_s                          exc_out,
    output logic [1:0]                         power_mode,
    output logic                               wake
);

    logic [NUM_SRC-1:0] req_vec;
    logic [NUM_SRC-1:0] periph_pend;
    logic [NUM_SRC-1:0] preempt_ok;
    logic [NUM_SYS-1:0] sys_pend;
    logic [NUM_SYS-1:0] next_sys_pend;
    logic [NUM_SYS-1:0] sys_event;
    logic               hard_pend;
    logic               next_hard_pend;
    logic [2:0]         fault_vec;
    logic               best_found;
    logic [6:0]         best_num;
    logic [2:0]         best_prio;
    eiwm_exc_s          next_exc;
    eiwm_state_e        state;
    eiwm_state_e        next_state;
    logic [1:0]         next_power_mode;
    logic               next_wake;
    logic               light_ok;
    logic               deep_ok;

    function automatic logic [6:0] slot_num(input int slot);
        logic [6:0] n;
        n = EXC_TICK;
        unique case (slot)
            SLOT_MEM:     n = EXC_MEM;
            SLOT_BUS:     n = EXC_BUS;
            SLOT_USAGE:   n = EXC_USAGE;
            SLOT_SVC:     n = EXC_SVC;
            SLOT_DEBUG:   n = EXC_DEBUG;
            SLOT_PENDSVC: n = EXC_PENDSVC;
            default:      n = EXC_TICK;
        endcase
        return n;
    endfunction

    // Source placement in the request vector
    always_comb begin
        req_vec                         = '0;
        req_vec[POS_WAKE_TMR]           = src.wake_timer;
        req_vec[POS_EXT0 +: 9]          = src.ext_irq;
        req_vec[POS_WDOG]               = src.watchdog;
        req_vec[POS_LV_DIE0]            = src.lv_die0;
        req_vec[POS_GPT0 +: 2]          = src.general_timer_lo;
        req_vec[POS_FLASH]              = src.flash;
        req_vec[POS_UART]               = src.uart;
        req_vec[POS_SPI0 +: 2]          = src.spi;
        req_vec[POS_TWI0_SLV]           = src.twi0_slave;
        req_vec[POS_TWI0_MST]           = src.twi0_master;
        req_vec[POS_PLB0 +: 2]          = src.prog_logic_lo;
        req_vec[POS_DMA_ERR]            = src.dma_err;
        req_vec[POS_DMA_DONE0 +: 14]    = src.dma_done;
        req_vec[POS_TWI1_SLV]           = src.twi1_slave;
        req_vec[POS_TWI1_MST]           = src.twi1_master;
        req_vec[POS_PLB2 +: 2]          = src.prog_logic_hi;
        req_vec[POS_GPT2]               = src.general_timer_two;
        req_vec[POS_LV_DIE1]            = src.lv_die1;
        req_vec[POS_PULSE_TRIP]         = src.pulse_trip;
        req_vec[POS_PULSE_PAIR0 +: 4]   = src.pulse_pair;
        // Level lines: pending lasts as long as the source holds it
        periph_pend = req_vec & src_enable & VALID_MASK;
    end

    // System exception pending flags
    always_comb begin
        fault_vec               = {usage_fault, bus_fault, mem_fault};
        sys_event               = '0;
        sys_event[SLOT_MEM]     = mem_fault & fault_handler_en[0];
        sys_event[SLOT_BUS]     = bus_fault & fault_handler_en[1];
        sys_event[SLOT_USAGE]   = usage_fault & fault_handler_en[2];
        sys_event[SLOT_SVC]     = svc_exec;
        sys_event[SLOT_DEBUG]   = debug_event;
        sys_event[SLOT_PENDSVC] = pend_svc_set;
        sys_event[SLOT_TICK]    = tick_event;
        next_sys_pend           = sys_pend;
        for (int i = 0; i < NUM_SYS; i++) begin
            if (core_ack && core_ack_num == slot_num(i)) begin
                next_sys_pend[i] = 1'b0;
            end
            // Set after clear so a same-cycle event survives the ack
            if (sys_event[i]) begin
                next_sys_pend[i] = 1'b1;
            end
        end
        next_hard_pend = hard_pend;
        if (core_ack && core_ack_num == EXC_HARD) begin
            next_hard_pend = 1'b0;
        end
        if (|(fault_vec & ~fault_handler_en)) begin
            next_hard_pend = 1'b1;
        end
    end

    // Arbitration: ascending number, strict compare keeps the lower one
    always_comb begin
        best_found = 1'b0;
        best_num   = '0;
        best_prio  = '0;
        preempt_ok = '0;
        for (int i = 0; i < NUM_SYS; i++) begin
            if (sys_pend[i] && (!handler_active || sys_prio[i] < active_prio)
                && (!best_found || sys_prio[i] < best_prio)) begin
                best_found = 1'b1;
                best_num   = slot_num(i);
                best_prio  = sys_prio[i];
            end
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            preempt_ok[i] = !handler_active
                            || src_prio[i] < active_prio;
            if (periph_pend[i] && preempt_ok[i]
                && (!best_found || src_prio[i] < best_prio)) begin
                best_found = 1'b1;
                best_num   = EXC_BASE + 7'(i);
                best_prio  = src_prio[i];
            end
        end
        next_exc = '0;
        if (hard_pend) begin
            // Fixed level above every programmable one
            next_exc.req  = 1'b1;
            next_exc.hard = 1'b1;
            next_exc.num  = EXC_HARD;
            next_exc.prio = PRIO_RESET;
        end else if (best_found) begin
            next_exc.req  = 1'b1;
            next_exc.num  = best_num;
            next_exc.prio = best_prio;
        end
    end

    // Low-power state and wake-up
    always_comb begin
        light_ok   = |(periph_pend & WAKE_M1 & preempt_ok);
        deep_ok    = |(periph_pend & WAKE_M23 & preempt_ok);
        next_state = state;
        next_wake  = 1'b0;
        unique case (state)
            ST_ACTIVE: begin
                if (sleep_req) begin
                    unique case (sleep_mode)
                        MODE_1:  next_state = ST_LIGHT;
                        MODE_2:  next_state = ST_DEEP2;
                        MODE_3:  next_state = ST_DEEP3;
                        default: next_state = ST_ACTIVE;
                    endcase
                end
            end
            ST_LIGHT: begin
                if (light_ok) begin
                    next_state = ST_ACTIVE;
                    next_wake  = 1'b1;
                end
            end
            ST_DEEP2, ST_DEEP3: begin
                if (deep_ok) begin
                    next_state = ST_ACTIVE;
                    next_wake  = 1'b1;
                end
            end
        endcase
        unique case (next_state)
            ST_LIGHT: next_power_mode = MODE_1;
            ST_DEEP2: next_power_mode = MODE_2;
            ST_DEEP3: next_power_mode = MODE_3;
            default:  next_power_mode = MODE_0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sys_pend   <= '0;
            hard_pend  <= 1'b0;
            exc_out    <= '0;
            state      <= ST_ACTIVE;
            power_mode <= MODE_0;
            wake       <= 1'b0;
        end else if (ce) begin
            sys_pend   <= next_sys_pend;
            hard_pend  <= next_hard_pend;
            exc_out    <= next_exc;
            state      <= next_state;
            power_mode <= next_power_mode;
            wake       <= next_wake;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_unhandled_mem;
        ce && mem_fault && !fault_handler_en[0];
    endsequence

    sequence s_quiet_two;
        (ce && !core_ack)[*2];
    endsequence

    property p_no_nmi;
        exc_out.req |-> exc_out.num != EXC_NMI;
    endproperty
    a_no_nmi: assert property (p_no_nmi)
        else $error("non-maskable exception raised");

    property p_unused_nums;
        exc_out.req |-> !(exc_out.num inside {[7'h07:7'h0a], 7'h0d,
            7'h1b, 7'h1c, 7'h1e, [7'h38:7'h3b]});
    endproperty
    a_unused_nums: assert property (p_unused_nums)
        else $error("reserved exception number raised");

    property p_hard_escalate;
        s_unhandled_mem ##1 s_quiet_two
            |-> exc_out.req && exc_out.hard && exc_out.num == EXC_HARD;
    endproperty
    a_hard_escalate: assert property (p_hard_escalate)
        else $error("unhandled fault did not reach hard fault");

    property p_light_wake;
        ce && state == ST_LIGHT && !handler_active
            && src.ext_irq[0] && src_enable[POS_EXT0]
            |=> wake && power_mode == MODE_0;
    endproperty
    a_light_wake: assert property (p_light_wake)
        else $error("mode 1 did not wake on enabled request");

    property p_deep_hold;
        ce && (state == ST_DEEP2 || state == ST_DEEP3)
            && !(|(periph_pend & WAKE_M23))
            |=> !wake && power_mode != MODE_0;
    endproperty
    a_deep_hold: assert property (p_deep_hold)
        else $error("deep mode woke without capable source");

    property p_wake_active;
        wake |-> power_mode == MODE_0 && state == ST_ACTIVE;
    endproperty
    a_wake_active: assert property (p_wake_active)
        else $error("wake did not return to mode 0");

    property p_prio_gate;
        ce && state != ST_ACTIVE && handler_active
            && !(|(periph_pend & preempt_ok)) |=> !wake;
    endproperty
    a_prio_gate: assert property (p_prio_gate)
        else $error("less urgent source woke the handler");

    property p_svc_held;
        ce && sys_pend[SLOT_PENDSVC]
            && !(core_ack && core_ack_num == EXC_PENDSVC)
            |=> sys_pend[SLOT_PENDSVC];
    endproperty
    a_svc_held: assert property (p_svc_held)
        else $error("pendable service request lost before ack");

endmodule

// ---- src/eiwm_pkg.sv ----
// Purpose: Constants and types for the exception and wake-up map
// Assumes: One clock domain, request lines held as levels
// Notes:   Position constants place each source in the request vector
package eiwm_pkg;

    localparam int          NUM_SRC  = 55;
    localparam int          PRIO_W   = 3;
    localparam int          EXC_W    = 7;
    localparam int          NUM_SYS  = 7;

    // Exception numbers
    localparam logic [6:0]  EXC_NMI     = 7'h02;
    localparam logic [6:0]  EXC_HARD    = 7'h03;
    localparam logic [6:0]  EXC_MEM     = 7'h04;
    localparam logic [6:0]  EXC_BUS     = 7'h05;
    localparam logic [6:0]  EXC_USAGE   = 7'h06;
    localparam logic [6:0]  EXC_SVC     = 7'h0b;
    localparam logic [6:0]  EXC_DEBUG   = 7'h0c;
    localparam logic [6:0]  EXC_PENDSVC = 7'h0e;
    localparam logic [6:0]  EXC_TICK    = 7'h0f;
    localparam logic [6:0]  EXC_BASE    = 7'h10;

    // System slots, in ascending exception number
    localparam int          SLOT_MEM     = 0;
    localparam int          SLOT_BUS     = 1;
    localparam int          SLOT_USAGE   = 2;
    localparam int          SLOT_SVC     = 3;
    localparam int          SLOT_DEBUG   = 4;
    localparam int          SLOT_PENDSVC = 5;
    localparam int          SLOT_TICK    = 6;

    localparam logic [2:0]  PRIO_RESET = 3'h0;

    // Request positions
    localparam int          POS_WAKE_TMR    = 0;
    localparam int          POS_EXT0        = 1;
    localparam int          POS_WDOG        = 10;
    localparam int          POS_LV_DIE0     = 13;
    localparam int          POS_GPT0        = 15;
    localparam int          POS_FLASH       = 17;
    localparam int          POS_UART        = 18;
    localparam int          POS_SPI0        = 19;
    localparam int          POS_TWI0_SLV    = 21;
    localparam int          POS_TWI0_MST    = 22;
    localparam int          POS_PLB0        = 23;
    localparam int          POS_DMA_ERR     = 25;
    localparam int          POS_DMA_DONE0   = 26;
    localparam int          POS_TWI1_SLV    = 44;
    localparam int          POS_TWI1_MST    = 45;
    localparam int          POS_PLB2        = 46;
    localparam int          POS_GPT2        = 48;
    localparam int          POS_LV_DIE1     = 49;
    localparam int          POS_PULSE_TRIP  = 50;
    localparam int          POS_PULSE_PAIR0 = 51;

    // Populated positions, and those that wake from modes 2 and 3
    localparam logic [54:0] VALID_MASK = 55'h7f_f0ff_ffff_a7ff;
    localparam logic [54:0] WAKE_M1    = VALID_MASK;
    localparam logic [54:0] WAKE_M23   = 55'h00_0000_0000_07ff;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_LIGHT  = 2'b01,
        ST_DEEP2  = 2'b11,
        ST_DEEP3  = 2'b10
    } eiwm_state_e;

    localparam logic [1:0]  MODE_0 = 2'h0;
    localparam logic [1:0]  MODE_1 = 2'h1;
    localparam logic [1:0]  MODE_2 = 2'h2;
    localparam logic [1:0]  MODE_3 = 2'h3;

    typedef struct packed {
        logic        wake_timer;
        logic [8:0]  ext_irq;
        logic        watchdog;
        logic        lv_die0;
        logic [1:0]  general_timer_lo;
        logic        flash;
        logic        uart;
        logic [1:0]  spi;
        logic        twi0_slave;
        logic        twi0_master;
        logic [1:0]  prog_logic_lo;
        logic        dma_err;
        logic [13:0] dma_done;
        logic        twi1_slave;
        logic        twi1_master;
        logic [1:0]  prog_logic_hi;
        logic        general_timer_two;
        logic        lv_die1;
        logic        pulse_trip;
        logic [3:0]  pulse_pair;
    } eiwm_src_s;

    typedef struct packed {
        logic       req;
        logic       hard;
        logic [6:0] num;
        logic [2:0] prio;
    } eiwm_exc_s;

endpackage

// ---- dv/eiwm_src_model.sv ----
// Purpose: Peripheral request sources facing the exception map
// Assumes: Set and clear strobes from the bench, one clock domain
// Notes:   Reserved positions have no line, so they never reach the map
`timescale 1ns/1ps

module eiwm_src_model
    import eiwm_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // Handler side strobes, by position
    input  wire logic [NUM_SRC-1:0] set_req,
    input  wire logic [NUM_SRC-1:0] clr_req,
    // Request lines
    output eiwm_src_s               src
);
    logic [NUM_SRC-1:0] lines;

    // Held until the handler clears it, never dropped on its own
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lines <= '0;
        end else begin
            lines <= (lines | set_req) & ~clr_req;
        end
    end

    always_comb begin
        src.wake_timer        = lines[0];
        src.ext_irq           = lines[9:1];
        src.watchdog          = lines[10];
        src.lv_die0           = lines[13];
        src.general_timer_lo  = lines[16:15];
        src.flash             = lines[17];
        src.uart              = lines[18];
        src.spi               = lines[20:19];
        src.twi0_slave        = lines[21];
        src.twi0_master       = lines[22];
        src.prog_logic_lo     = lines[24:23];
        src.dma_err           = lines[25];
        src.dma_done          = lines[39:26];
        src.twi1_slave        = lines[44];
        src.twi1_master       = lines[45];
        src.prog_logic_hi     = lines[47:46];
        src.general_timer_two = lines[48];
        src.lv_die1           = lines[49];
        src.pulse_trip        = lines[50];
        src.pulse_pair        = lines[54:51];
    end
endmodule

// ---- dv/test_exception_interrupt_wakeup_map.sv ----
// Purpose: Self-checking bench for the exception and wake-up map
// Assumes: Inputs change on the falling edge; core role played here
// Notes:   Waits are padded; levels hold, so late sampling is safe
`timescale 1ns/1ps

module test_exception_interrupt_wakeup_map
    import eiwm_pkg::*;
;
    localparam logic [6:0] SYS_NUM [7] = '{EXC_MEM, EXC_BUS, EXC_USAGE,
        EXC_SVC, EXC_DEBUG, EXC_PENDSVC, EXC_TICK};

    logic                              clk;
    logic                              reset;
    logic                              ce;
    eiwm_src_s                         src;
    logic [NUM_SRC-1:0]                set_req;
    logic [NUM_SRC-1:0]                clr_req;
    logic [NUM_SRC-1:0]                src_enable;
    logic [NUM_SRC-1:0][PRIO_W-1:0]    src_prio;
    logic [NUM_SYS-1:0]                sys_pulse;
    logic [2:0]                        fault_handler_en;
    logic [NUM_SYS-1:0][PRIO_W-1:0]    sys_prio;
    logic                              handler_active;
    logic [PRIO_W-1:0]                 active_prio;
    logic                              core_ack;
    logic [EXC_W-1:0]                  core_ack_num;
    logic                              sleep_req;
    logic [1:0]                        sleep_mode;
    eiwm_exc_s                         exc_out;
    logic [1:0]                        power_mode;
    logic                              wake;
    int                                err_count;
    int                                checks;
    int                                cycles;

    eiwm_src_model srcs (.clk(clk), .reset(reset), .set_req(set_req),
        .clr_req(clr_req), .src(src));

    eiwm_core dut (.clk(clk), .reset(reset), .ce(ce), .src(src),
        .src_enable(src_enable), .src_prio(src_prio),
        .mem_fault(sys_pulse[0]), .bus_fault(sys_pulse[1]),
        .usage_fault(sys_pulse[2]), .fault_handler_en(fault_handler_en),
        .svc_exec(sys_pulse[3]), .debug_event(sys_pulse[4]),
        .pend_svc_set(sys_pulse[5]), .tick_event(sys_pulse[6]),
        .sys_prio(sys_prio), .handler_active(handler_active),
        .active_prio(active_prio), .core_ack(core_ack),
        .core_ack_num(core_ack_num), .sleep_req(sleep_req),
        .sleep_mode(sleep_mode), .exc_out(exc_out),
        .power_mode(power_mode), .wake(wake));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling well above the 794 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic cmp_exc(string what, eiwm_exc_s exp);
        checks++;
        if (exc_out !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, exc_out);
        end
    endtask

    task automatic cmp_bit(string what, logic exp, logic seen);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic cmp_mode(logic [1:0] exp);
        checks++;
        if (power_mode !== exp) begin
            err_count++;
            $display("mismatch power_mode expected %h seen %h", exp,
                power_mode);
        end
    endtask

    function automatic eiwm_exc_s mk(logic h, logic [6:0] n, logic [2:0] p);
        mk = {1'b1, h, n, p};
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic put(int pos, logic on);
        logic [NUM_SRC-1:0] one;
        one = '0;
        one[pos] = 1'b1;
        // Strobes stay up until the next call; set and clear are idempotent
        set_req = on ? one : '0;
        clr_req = on ? '0 : one;
        tick(0);
    endtask

    task automatic pulse_ack(int i, logic [6:0] n);
        sys_pulse[i] = 1'b1;
        tick(0);
        sys_pulse = '0;
        tick(3);
        core_ack = 1'b1;
        core_ack_num = n;
        tick(0);
        core_ack = 1'b0;
        tick(2);
        cmp_exc("exc cleared", '0);
    endtask

    task automatic t_reset();
        cmp_exc("exc after reset", '0);
        cmp_mode(MODE_0);
        cmp_bit("wake after reset", 1'b0, wake);
    endtask

    task automatic t_system();
        fault_handler_en = 3'h7;
        for (int i = 0; i < NUM_SYS; i++) begin
            sys_prio[i] = 3'(i);
            sys_pulse[i] = 1'b1;
            tick(0);
            sys_pulse = '0;
            tick(6);
            cmp_exc("sys exc",
                mk(1'b0, SYS_NUM[i], 3'(i)));
            pulse_ack(i, SYS_NUM[i]);
        end
        fault_handler_en = 3'h0;
        for (int i = 0; i < 3; i++) begin
            sys_pulse[i] = 1'b1;
            tick(0);
            sys_pulse = '0;
            tick(3);
            cmp_exc("hard fault", mk(1'b1, EXC_HARD, 3'h0));
            pulse_ack(i, EXC_HARD);
        end
        sys_prio = '0;
    endtask

    task automatic t_positions();
        ce = 1'b0;
        put(5, 1'b1);
        tick(3);
        cmp_exc("frozen exc", '0);
        ce = 1'b1;
        put(5, 1'b0);
        tick(3);
        for (int p = 0; p < NUM_SRC; p++) begin
            put(p, 1'b1);
            tick(3);
            cmp_exc("position", VALID_MASK[p] ?
                mk(1'b0, EXC_BASE + 7'(p), 3'h0) : '0);
            put(p, 1'b0);
            tick(3);
        end
    endtask

    task automatic t_order();
        src_prio[19] = 3'h1;
        src_prio[20] = 3'h1;
        put(20, 1'b1);
        put(19, 1'b1);
        tick(3);
        cmp_exc("tie", mk(1'b0, EXC_BASE + 7'(19), 3'h1));
        put(48, 1'b1);
        tick(3);
        cmp_exc("urgent", mk(1'b0, EXC_BASE + 7'(48), 3'h0));
        sys_pulse[6] = 1'b1;
        tick(0);
        sys_pulse = '0;
        tick(3);
        cmp_exc("sys first", mk(1'b0, EXC_TICK, 3'h0));
        core_ack = 1'b1;
        core_ack_num = EXC_TICK;
        tick(0);
        core_ack = 1'b0;
        for (int p = 19; p < 49; p++) put(p, 1'b0);
        src_prio = '0;
        tick(3);
    endtask

    // Sleep, raise one source, count wake pulses, then recover
    task automatic try_wake(logic [1:0] m, int pos, logic exp);
        int n;
        n = 0;
        sleep_mode = m;
        sleep_req = 1'b1;
        tick(0);
        sleep_req = 1'b0;
        tick(0);
        cmp_mode(m);
        put(pos, 1'b1);
        repeat (5) begin
            n += (wake === 1'b1) ? 1 : 0;
            tick(0);
        end
        cmp_bit("wake", exp, n == 1);
        if (!exp) begin
            cmp_mode(m);
            put(1, 1'b1);
            tick(3);
        end
        cmp_mode(MODE_0);
        put(pos, 1'b0);
        put(1, 1'b0);
        tick(3);
    endtask

    task automatic t_wake();
        // Mode 0 request is not a sleep; device stays active
        sleep_mode = MODE_0;
        sleep_req = 1'b1;
        tick(0);
        sleep_req = 1'b0;
        tick(1);
        cmp_mode(MODE_0);
        try_wake(MODE_1, 30, 1'b1);
        try_wake(MODE_2, 5, 1'b1);
        try_wake(MODE_3, 10, 1'b1);
        try_wake(MODE_2, 13, 1'b0);
        try_wake(MODE_3, 30, 1'b0);
        try_wake(MODE_1, 11, 1'b0);
        src_enable[18] = 1'b0;
        try_wake(MODE_1, 18, 1'b0);
        src_enable[18] = 1'b1;
        handler_active = 1'b1;
        active_prio = 3'h2;
        src_prio[17] = 3'h2;
        try_wake(MODE_1, 17, 1'b0);
        src_prio[17] = 3'h1;
        try_wake(MODE_3, 17, 1'b0);
        try_wake(MODE_1, 17, 1'b1);
        handler_active = 1'b0;
    endtask

    initial begin
        {err_count, checks, cycles} = '0;
        {set_req, clr_req, src_prio, sys_pulse, sys_prio} = '0;
        {handler_active, active_prio, core_ack, core_ack_num} = '0;
        {sleep_req, sleep_mode, fault_handler_en} = '0;
        src_enable = '1;
        ce = 1'b1;
        reset = 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_system();
        t_positions();
        t_order();
        t_wake();
        close_out();
    end
endmodule
